// >>> boolean_logic_pkg.sv
// Constants, types and register map of the boolean logic unit
// Function
// - Capture index and both source operands every clock, whatever instruction is present.
// - Capture at issue, deliver result next clock; a new instruction every clock.
// - Without issue the captured operands go unused and are replaced next clock.
// - Go strobe comes the clock after issue; destinations written only then.
// - Register function bit 0 and mode bits 0-2 each clock, then decode.
// - Result bits 48-59 merge three paths; idle paths give all ones.
// - Opcodes 11 and 15 write AND of sources; 15 inverts second first.
// - Opcodes 12 and 16 write OR via inverted AND merged with equivalence.
// - Opcodes 13 and 17 write XOR via equivalence with AND path off.
// - Opcode 10 copies first source; opcode 14 copies inverted second source.
// - Unpack copies source bits 0-47 into destination bits 0-47.
// - Unpack fills destination bits 48-59 with sign from source bit 59.
// - Unpack index bits 0-9 from source 48-57, inverted when coefficient positive.
// - Unpack exponent sign from inverted XOR of bits 58, 59, into index bits 10-17.
// - Unpacked exponent is the unbiased ones-complement exponent value.
// - Index register written by this unit only for opcode 26.
// - Pack ignores index bit 11, a copy of the exponent sign.
// - Pack puts index 0-10 at 48-58 with sign-dependent inversion pattern.
// - Pack sets destination bit 59 from the coefficient sign, source bit 59.
// - Pack passes source bits 0-47 and blocks source bits 48-59.
package boolean_logic_pkg;

	// ***********************************************************
	// Widths and field positions
	// ***********************************************************
	localparam int WORD_W      = 60;
	localparam int INDEX_W     = 18;
	localparam int UPPER_W     = 12;
	localparam int COEF_MSB    = 47;
	localparam int EXP_LSB     = 48;
	localparam int EXP_MSB     = 57;
	localparam int EXP_SIGN    = 58;
	localparam int WORD_SIGN   = 59;
	localparam int EXP_W       = 10;
	localparam int PACK_SIGN   = 10;
	localparam int PACK_EXP_W  = 11;
	localparam int IDX_EXT_W   = 8;

	// ***********************************************************
	// Opcodes as {function bit 0, mode bits 2..0}
	// ***********************************************************
	localparam logic [3:0] OP_COPY_FIRST = 4'h8;
	localparam logic [3:0] OP_AND        = 4'h9;
	localparam logic [3:0] OP_OR         = 4'ha;
	localparam logic [3:0] OP_XOR        = 4'hb;
	localparam logic [3:0] OP_COPY_INV   = 4'hc;
	localparam logic [3:0] OP_AND_INV    = 4'hd;
	localparam logic [3:0] OP_OR_INV     = 4'he;
	localparam logic [3:0] OP_XOR_INV    = 4'hf;
	localparam logic [3:0] OP_UNPACK     = 4'h6;
	localparam logic [3:0] OP_PACK       = 4'h7;

	// ***********************************************************
	// Register map (byte addresses)
	// ***********************************************************
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [7:0]  REG_RES_LO   = 8'h08;
	localparam logic [7:0]  REG_RES_HI   = 8'h0c;
	localparam logic [7:0]  REG_INDEX    = 8'h10;
	localparam logic [7:0]  REG_COUNT    = 8'h14;
	localparam int          CTRL_ENABLE  = 0;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
	localparam int          RES_HI_W     = 28;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

	// ***********************************************************
	// Carriers
	// ***********************************************************
	typedef struct packed {
		logic [INDEX_W-1:0] index;
		logic [WORD_W-1:0]  first;
		logic [WORD_W-1:0]  second;
	} operand_s;

	typedef struct packed {
		logic       func0;
		logic [2:0] mode;
	} designator_s;

	typedef struct packed {
		logic               dest_write;
		logic [WORD_W-1:0]  dest_data;
		logic               index_write;
		logic [INDEX_W-1:0] index_data;
	} result_s;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
	} bus_phase_s;

endpackage

// >>> boolean_logic_unit.sv
// Boolean logic unit datapath with AHB-Lite status and control registers
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module boolean_logic_unit (
	input  wire logic                                 hclk,
	input  wire logic                                 hresetn,
	input  wire logic                                 hsel,
	input  wire logic [31:0]                          haddr,
	input  wire logic [1:0]                           htrans,
	input  wire logic                                 hwrite,
	input  wire logic [2:0]                           hsize,
	input  wire logic [31:0]                          hwdata,
	input  wire logic                                 hready,
	output logic                                      hreadyout,
	output logic                                      hresp,
	output logic [31:0]                               hrdata,
	input  wire boolean_logic_pkg::operand_s          operands,
	input  wire boolean_logic_pkg::designator_s       designators,
	input  wire logic                                 go_boolean,
	output logic [boolean_logic_pkg::WORD_W-1:0]      dest_operand_reg,
	output logic [boolean_logic_pkg::INDEX_W-1:0]     dest_index_reg,
	output logic                                      dest_written,
	output logic                                      index_written
);
	import boolean_logic_pkg::*;

	// ***********************************************************
	// Input and designator capture
	// ***********************************************************
	logic [INDEX_W-1:0] index_operand_reg;
	logic [WORD_W-1:0]  first_source_reg;
	logic [WORD_W-1:0]  second_source_reg;
	logic [3:0]         instruction_word_reg;

	// Loaded unconditionally; no issue qualifier on purpose
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			index_operand_reg <= '0;
			first_source_reg  <= '0;
			second_source_reg <= '0;
		end else begin
			index_operand_reg <= operands.index;
			first_source_reg  <= operands.first;
			second_source_reg <= operands.second;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instruction_word_reg <= '0;
		end else begin
			instruction_word_reg <= {designators.func0, designators.mode};
		end
	end

	// ***********************************************************
	// Control translator
	// ***********************************************************
	logic and_path_enable;
	logic first_source_path_enable;
	logic second_source_high_enable;
	logic second_source_low_enable;
	logic second_source_invert;
	logic op_unpack;
	logic op_pack;
	logic op_valid;

	always_comb begin
		and_path_enable           = 1'b0;
		first_source_path_enable  = 1'b0;
		second_source_high_enable = 1'b0;
		second_source_low_enable  = 1'b0;
		second_source_invert      = 1'b0;
		op_unpack                 = 1'b0;
		op_pack                   = 1'b0;
		op_valid                  = 1'b1;
		unique case (instruction_word_reg)
			OP_COPY_FIRST: begin
				first_source_path_enable = 1'b1;
			end
			OP_AND: begin
				and_path_enable = 1'b1;
			end
			OP_AND_INV: begin
				and_path_enable      = 1'b1;
				second_source_invert = 1'b1;
			end
			OP_OR, OP_OR_INV: begin
				and_path_enable           = 1'b1;
				first_source_path_enable  = 1'b1;
				second_source_high_enable = 1'b1;
				second_source_low_enable  = 1'b1;
				second_source_invert      = instruction_word_reg[2];
			end
			OP_XOR, OP_XOR_INV: begin
				first_source_path_enable  = 1'b1;
				second_source_high_enable = 1'b1;
				second_source_low_enable  = 1'b1;
				second_source_invert      = instruction_word_reg[2];
			end
			OP_COPY_INV: begin
				second_source_high_enable = 1'b1;
				second_source_low_enable  = 1'b1;
				second_source_invert      = 1'b1;
			end
			OP_UNPACK: begin
				second_source_low_enable = 1'b1;
				op_unpack                = 1'b1;
			end
			OP_PACK: begin
				second_source_low_enable = 1'b1;
				op_pack                  = 1'b1;
			end
			default: begin
				// Function codes outside this unit never write
				op_valid = 1'b0;
			end
		endcase
	end

	// ***********************************************************
	// Static network, worked in complemented form
	// ***********************************************************
	logic [WORD_W-1:0]     second_mod;
	logic [WORD_W-1:0]     gated_first;
	logic [WORD_W-1:0]     gated_second;
	logic [WORD_W-1:0]     product_n;
	logic [WORD_W-1:0]     equiv;
	logic [WORD_W-1:0]     logic_n;
	logic [UPPER_W-1:0]    extend_n;
	logic [UPPER_W-1:0]    pack_n;
	logic [PACK_EXP_W-1:0] pack_exp;
	logic                  pack_sign;
	logic [WORD_W-1:0]     result_word;
	logic                  coef_negative;
	logic                  exponent_sign_bit;
	logic [INDEX_W-1:0]    result_index;

	assign coef_negative = second_source_reg[WORD_SIGN];
	assign second_mod    = second_source_invert ? ~second_source_reg : second_source_reg;

	always_comb begin
		gated_first  = first_source_path_enable ? first_source_reg : '0;
		gated_second = '0;
		if (second_source_low_enable) begin
			gated_second[COEF_MSB:0] = second_mod[COEF_MSB:0];
		end
		// Upper bits stay blocked for pack and unpack
		if (second_source_high_enable) begin
			gated_second[WORD_SIGN:EXP_LSB] = second_mod[WORD_SIGN:EXP_LSB];
		end
	end

	// Idle product path yields all ones so it acts as a merge
	assign product_n = ~(first_source_reg & second_mod & {WORD_W{and_path_enable}});
	assign equiv     = ~(gated_first ^ gated_second);
	assign logic_n   = product_n & equiv;

	// Sign extension path for unpack
	assign extend_n = op_unpack ? {UPPER_W{~coef_negative}} : {UPPER_W{1'b1}};

	// Bit 11 of the index is never looked at
	always_comb begin
		pack_exp = index_operand_reg[PACK_SIGN:0];
		if (coef_negative) begin
			pack_exp[EXP_W-1:0] = ~index_operand_reg[EXP_W-1:0];
		end else begin
			pack_exp[PACK_SIGN] = ~index_operand_reg[PACK_SIGN];
		end
	end
	assign pack_sign = coef_negative;
	assign pack_n    = op_pack ? ~{pack_sign, pack_exp} : {UPPER_W{1'b1}};

	always_comb begin
		result_word = ~logic_n;
		// Only one of three upper sources is active at a time
		result_word[WORD_SIGN:EXP_LSB] = ~(logic_n[WORD_SIGN:EXP_LSB] & extend_n & pack_n);
	end

	// Unbias: positive coefficient inverts exponent field
	assign exponent_sign_bit = second_source_reg[EXP_SIGN] ^ second_source_reg[WORD_SIGN];
	always_comb begin
		result_index = '0;
		result_index[EXP_W-1:0] = coef_negative ? second_source_reg[EXP_MSB:EXP_LSB]
		                                        : ~second_source_reg[EXP_MSB:EXP_LSB];
		result_index[INDEX_W-1:EXP_W] = {IDX_EXT_W{~exponent_sign_bit}};
	end

	// ***********************************************************
	// Destination registers
	// ***********************************************************
	logic   unit_enable;
	logic   write_go;
	logic   next_dest_written;
	logic   next_index_written;

	assign write_go           = go_boolean & op_valid & unit_enable;
	assign next_dest_written  = write_go;
	assign next_index_written = write_go & op_unpack;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dest_operand_reg <= '0;
		end else if (next_dest_written) begin
			dest_operand_reg <= result_word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dest_index_reg <= '0;
		end else if (next_index_written) begin
			dest_index_reg <= result_index;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dest_written  <= 1'b0;
			index_written <= 1'b0;
		end else begin
			dest_written  <= next_dest_written;
			index_written <= next_index_written;
		end
	end

	// ***********************************************************
	// Activity tracking for software
	// ***********************************************************
	logic [3:0]  last_opcode;
	logic [31:0] result_count;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_opcode <= '0;
		end else if (next_dest_written) begin
			last_opcode <= instruction_word_reg;
		end
	end

	// Wraps silently; software samples the difference
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_count <= '0;
		end else if (next_dest_written) begin
			result_count <= result_count + 32'h0000_0001;
		end
	end

	// ***********************************************************
	// AHB-Lite slave, zero wait states
	// ***********************************************************
	bus_phase_s  data_phase;
	logic        data_phase_valid;
	logic        addr_take;
	logic [31:0] ctrl_reg;
	logic [31:0] next_ctrl;
	logic [31:0] read_value;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);
	assign unit_enable = ctrl_reg[CTRL_ENABLE];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_phase       <= '0;
			data_phase_valid <= 1'b0;
		end else if (hready) begin
			data_phase_valid <= addr_take;
			data_phase.write <= hwrite;
			data_phase.addr  <= haddr[ADDR_W-1:0];
		end
	end

	always_comb begin
		next_ctrl = ctrl_reg;
		if (data_phase_valid && data_phase.write && data_phase.addr == REG_CTRL) begin
			next_ctrl = 32'h0000_0000;
			next_ctrl[CTRL_ENABLE] = hwdata[CTRL_ENABLE];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= CTRL_RESET;
		end else begin
			ctrl_reg <= next_ctrl;
		end
	end

	// Read value forwards a write landing in the same cycle
	always_comb begin
		read_value = 32'h0000_0000;
		unique case (haddr[ADDR_W-1:0])
			REG_CTRL:   read_value = next_ctrl;
			REG_STATUS: read_value = {26'h000_0000, index_written, dest_written, last_opcode};
			REG_RES_LO: read_value = dest_operand_reg[31:0];
			REG_RES_HI: read_value = {4'h0, dest_operand_reg[WORD_W-1:WORD_W-RES_HI_W]};
			REG_INDEX:  read_value = {14'h0000, dest_index_reg};
			REG_COUNT:  read_value = result_count;
			default:    read_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (addr_take && !hwrite) begin
			hrdata <= read_value;
		end
	end

endmodule

// >>> boolean_logic_unit_checker.sv
// Concurrent checks on the boolean unit datapath ports
`timescale 1ns/1ps
module boolean_logic_unit_checker (
	input wire logic                                  hclk,
	input wire logic                                  hresetn,
	input wire boolean_logic_pkg::operand_s           operands,
	input wire boolean_logic_pkg::designator_s        designators,
	input wire logic                                  go_boolean,
	input wire logic [boolean_logic_pkg::WORD_W-1:0]  dest_operand_reg,
	input wire logic [boolean_logic_pkg::INDEX_W-1:0] dest_index_reg,
	input wire logic                                  dest_written,
	input wire logic                                  index_written
);
	import boolean_logic_pkg::*;
	// ********************************
	// Issue history
	// ********************************
	// Two deep: a result shows two edges after its operands were presented
	operand_s          o1, o2;
	designator_s       d1, d2;
	logic [WORD_W-1:0] k;
	always_ff @(posedge hclk) begin
		o1 <= operands;
		o2 <= o1;
		d1 <= designators;
		d2 <= d1;
	end
	assign k = d2.mode[2] ? ~o2.second : o2.second;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_write_after_go: assert property (dest_written |-> $past(go_boolean))
		else $error("write without go strobe");
	a_idle_no_write: assert property (!go_boolean |=> !dest_written && !index_written)
		else $error("write in idle cycle");
	a_index_unpack_only: assert property (index_written |-> dest_written && d2 == OP_UNPACK)
		else $error("index written by other opcode");
	a_logic_and: assert property (dest_written && (d2 == OP_AND || d2 == OP_AND_INV)
		|-> dest_operand_reg == (o2.first & k)) else $error("and result wrong");
	a_logic_or: assert property (dest_written && (d2 == OP_OR || d2 == OP_OR_INV)
		|-> dest_operand_reg == (o2.first | k)) else $error("or result wrong");
	a_logic_xor: assert property (dest_written && (d2 == OP_XOR || d2 == OP_XOR_INV)
		|-> dest_operand_reg == (o2.first ^ k)) else $error("xor result wrong");
	a_copy_word: assert property (dest_written && (d2 == OP_COPY_FIRST || d2 == OP_COPY_INV)
		|-> dest_operand_reg == (d2.mode[2] ? k : o2.first)) else $error("copy wrong");
	a_unpack_word: assert property (dest_written && d2 == OP_UNPACK
		|-> dest_operand_reg == {{12{o2.second[59]}}, o2.second[47:0]} && index_written
		&& dest_index_reg == {{8{~(o2.second[58] ^ o2.second[59])}},
		o2.second[57:48] ^ {10{~o2.second[59]}}}) else $error("unpack wrong");
	a_pack_word: assert property (dest_written && d2 == OP_PACK
		|-> dest_operand_reg == {o2.second[59], o2.index[10] ^ ~o2.second[59],
		o2.index[9:0] ^ {10{o2.second[59]}}, o2.second[47:0]}) else $error("pack wrong");
endmodule

// >>> boolean_logic_unit_tb.sv
// Self-checking bench for the boolean logic unit
`timescale 1ns/1ps
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module boolean_logic_unit_tb;
	import boolean_logic_pkg::*;
	// ********************************
	// Bench
	// ********************************
	logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, go_boolean;
	logic               dest_written, index_written;
	logic [31:0]        haddr, hwdata, hrdata, rd;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	operand_s           operands;
	designator_s        designators;
	logic [WORD_W-1:0]  dest_operand_reg, last;
	logic [INDEX_W-1:0] dest_index_reg;
	logic [3:0]         codes [13] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf,
		4'h6, 4'h6, 4'h7, 4'h7, 4'h0};
	int                 failures, checks_done;
	initial hclk = 1'b0;
	always #2 hclk = ~hclk;
	boolean_logic_unit i_boolean_logic_unit (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.operands(operands), .designators(designators), .go_boolean(go_boolean),
		.dest_operand_reg(dest_operand_reg), .dest_index_reg(dest_index_reg),
		.dest_written(dest_written), .index_written(index_written));
	issue_control_model i_issue_control_model (.hclk(hclk), .operands(operands),
		.designators(designators), .go_boolean(go_boolean));
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	function automatic operand_s opnd(input int i);
		operand_s o;
		o.first = 60'h0f0_f0f0_a5a5_3c3c ^ (60'(i) * 60'h111_1111_1111_1111);
		o.second = 60'h5a5_0ff0_c3c3_9669 ^ {i[0], i[1], 58'(i) << 48};
		// Bit 11 toggles against bit 10 so pack must really ignore it
		o.index = 18'h2_a5c3 ^ 18'(i) ^ {6'h00, i[0], 11'h000};
		return o;
	endfunction
	function automatic logic [WORD_W-1:0] exp_dest(input logic [3:0] c, input operand_s o);
		logic [WORD_W-1:0] k;
		k = c[2] ? ~o.second : o.second;
		case (c)
			4'h8: return o.first;
			4'h9, 4'hd: return o.first & k;
			4'ha, 4'he: return o.first | k;
			4'hb, 4'hf: return o.first ^ k;
			4'hc: return k;
			4'h6: return {{12{o.second[59]}}, o.second[47:0]};
			default: return {o.second[59], o.index[10] ^ ~o.second[59],
				o.index[9:0] ^ {10{o.second[59]}}, o.second[47:0]};
		endcase
	endfunction
	task automatic t_regs;
		bus(1'b0, REG_CTRL, 32'h0);
		`CHECK(rd, CTRL_RESET)
		bus(1'b0, 8'h40, 32'h0);
		`CHECK(rd, 32'h0)
		`CHECK(hresp, 1'b0)
	endtask
	// Every opcode back to back; the unused code last, so it must leave the result alone
	task automatic t_stream;
		int                 j;
		logic               v;
		operand_s           o;
		logic [INDEX_W-1:0] li;
		for (int i = 0; i < 15; i++) begin
			i_issue_control_model.step(i < 13, designator_s'(codes[i % 13]), opnd(i));
			#1;
			if (i >= 2) begin
				j = i - 2;
				o = opnd(j);
				v = codes[j][3] || codes[j] == 4'h6 || codes[j] == 4'h7;
				if (v)
					last = exp_dest(codes[j], o);
				`CHECK(dest_written, v)
				`CHECK(dest_operand_reg, last)
				`CHECK(index_written, codes[j] == 4'h6)
				if (codes[j] == 4'h6) begin
					li = {{8{~(o.second[58] ^ o.second[59])}},
						o.second[57:48] ^ {10{~o.second[59]}}};
					`CHECK(dest_index_reg, li)
				end
			end
		end
		bus(1'b0, REG_COUNT, 32'h0);
		`CHECK(rd, 32'h0000_000c)
		bus(1'b0, REG_RES_LO, 32'h0);
		`CHECK(rd, last[31:0])
		bus(1'b0, REG_RES_HI, 32'h0);
		`CHECK(rd, {4'h0, last[59:32]})
		bus(1'b0, REG_INDEX, 32'h0);
		`CHECK(rd, {14'h0000, li})
		bus(1'b0, REG_STATUS, 32'h0);
		`CHECK(rd, 32'h0000_0007)
	endtask
	task automatic t_enable;
		bus(1'b1, REG_CTRL, 32'h0);
		bus(1'b0, REG_CTRL, 32'h0);
		`CHECK(rd, 32'h0)
		i_issue_control_model.step(1'b1, designator_s'(OP_AND), opnd(3));
		repeat (2) begin
			i_issue_control_model.step(1'b0, designator_s'(4'h0), opnd(0));
			#1;
			`CHECK(dest_written, 1'b0)
		end
		`CHECK(dest_operand_reg, last)
		bus(1'b1, REG_CTRL, CTRL_RESET);
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		last = '0;
		failures = 0;
		checks_done = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_stream;
		t_enable;
		report_and_stop;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#20000;
		failures++;
		report_and_stop;
	end
endmodule
bind boolean_logic_unit boolean_logic_unit_checker i_boolean_logic_unit_checker (
	.hclk(hclk), .hresetn(hresetn), .operands(operands), .designators(designators),
	.go_boolean(go_boolean), .dest_operand_reg(dest_operand_reg),
	.dest_index_reg(dest_index_reg), .dest_written(dest_written),
	.index_written(index_written));

// >>> issue_control_model.sv
// Issue control model feeding operands, designators and go strobe
`timescale 1ns/1ps
module issue_control_model (
	input  wire logic                      hclk,
	output boolean_logic_pkg::operand_s    operands,
	output boolean_logic_pkg::designator_s designators,
	output logic                           go_boolean
);
	import boolean_logic_pkg::*;
	// ********************************
	// One clock per call
	// ********************************
	logic pend;
	initial begin
		operands = '0;
		designators = '0;
		go_boolean = 1'b0;
		pend = 1'b0;
	end
	// Idle cycles still change operands, so stale data is never mistaken
	task automatic step(input logic iss, input designator_s d, input operand_s o);
		@(posedge hclk);
		operands <= iss ? o : ~operands;
		designators <= iss ? d : ~designators;
		go_boolean <= pend;
		pend = iss;
	endtask
endmodule
